// >>> hdl/lpi_readout.sv
// result registers, threshold watch and interrupt flags
// Overview of operation
// - the ambient result is a 16-bit value, upper byte 85h, lower 86h.
// - both ambient result bytes are read-only and host writes do nothing.
// - the proximity result is a 16-bit value, upper byte 87h, lower 88h.
// - both proximity result bytes are read-only against host writes.
// - a 3-bit count field at 89h needs 2**n straight out-of-range samples.
// - separate enables raise flags on new ambient and proximity results.
// - a threshold enable flags the watched value above high or below low.
// - with the select bit at 0 the thresholds watch proximity results.
// - with the select bit at 1 the thresholds watch ambient results.
// - while self-timed mode runs a new ambient parameter waits until the mode stops.
// - low threshold sits at 8Ah/8Bh and high threshold at 8Ch/8Dh.
// - each status flag stays 1 until the host writes 1 to its bit.
// - the interrupt pin is pulled low while any status flag is 1.
module lpi_readout
  import lpi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  output logic sda_pin_out,
  output logic sda_pin_oe,
  output logic int_pad_out,
  output logic int_pad_oe,
  input wire logic [15:0] als_in,
  input wire logic als_valid,
  input wire logic [15:0] prox_in,
  input wire logic prox_valid,
  input wire logic self_timed_en,
  input wire logic [7:0] als_param_in,
  output logic [7:0] als_param_applied
);
  lpi_reg_if bus ();
  lpi_core_st_t r;
  lpi_core_st_t n;
  logic [7:0] rd;
  logic [7:0] persist_tgt;
  logic sel_als;
  logic sel_valid;
  logic [15:0] sel_val;
  logic above;
  logic below;
  logic [LPI_ST_W-1:0] set_v;
  logic [LPI_ST_W-1:0] clr_v;

  lpi_i2c_slave u_slave (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .scl_pin(scl_pin),
    .sda_pin_in(sda_pin_in),
    .sda_pin_out(sda_pin_out),
    .sda_pin_oe(sda_pin_oe),
    .bus(bus.engine)
  );

  // watched measurement and its limits
  assign persist_tgt = 8'h01 << r.ctrl[LPI_CNT_LSB +: LPI_CNT_W];
  assign sel_als = r.ctrl[LPI_THR_SEL];
  assign sel_valid = sel_als ? als_valid : prox_valid;
  assign sel_val = sel_als ? als_in : prox_in;
  assign above = sel_val > r.thr_hi;
  assign below = sel_val < r.thr_lo;

  always_comb begin
    n = r;
    rd = LPI_RD_NONE;
    set_v = '0;
    clr_v = '0;
    // both bytes of a pair load in the same cycle
    if (als_valid) begin
      n.als = als_in;
    end
    if (prox_valid) begin
      n.prox = prox_in;
    end
    // parameter held while self-timed runs
    n.st_prev = self_timed_en;
    if (!self_timed_en || !r.st_prev) begin
      n.param = als_param_in;
    end
    // data ready flags
    if (als_valid && r.ctrl[LPI_ALS_EN]) begin
      set_v[LPI_ST_ALS] = 1'b1;
    end
    if (prox_valid && r.ctrl[LPI_PROX_EN]) begin
      set_v[LPI_ST_PROX] = 1'b1;
    end
    // consecutive out-of-range counting
    if (sel_valid) begin
      if (above || below) begin
        if (8'(r.run_cnt + 8'h01) >= persist_tgt) begin
          n.run_cnt = '0;
          if (r.ctrl[LPI_THR_EN]) begin
            set_v[LPI_ST_HIGH] = above;
            set_v[LPI_ST_LOW] = below;
          end
        end else begin
          n.run_cnt = 8'(r.run_cnt + 8'h01);
        end
      end else begin
        n.run_cnt = '0;
      end
    end
    // host register writes
    if (bus.wr) begin
      if (bus.addr == LPI_ADDR_CTRL) begin
        n.ctrl = bus.wdata;
      end else if (bus.addr == LPI_ADDR_TLO_HI) begin
        n.thr_lo[15:8] = bus.wdata;
      end else if (bus.addr == LPI_ADDR_TLO_LO) begin
        n.thr_lo[7:0] = bus.wdata;
      end else if (bus.addr == LPI_ADDR_THI_HI) begin
        n.thr_hi[15:8] = bus.wdata;
      end else if (bus.addr == LPI_ADDR_THI_LO) begin
        n.thr_hi[7:0] = bus.wdata;
      end else if (bus.addr == LPI_ADDR_STATUS) begin
        clr_v = bus.wdata[LPI_ST_W-1:0];
      end
      // result addresses fall through untouched
    end
    // new event wins over a clear in the same cycle
    n.flags = (r.flags & ~clr_v) | set_v;
    // register read mux
    if (bus.addr == LPI_ADDR_ALS_HI) begin
      rd = r.als[15:8];
    end else if (bus.addr == LPI_ADDR_ALS_LO) begin
      rd = r.als[7:0];
    end else if (bus.addr == LPI_ADDR_PROX_HI) begin
      rd = r.prox[15:8];
    end else if (bus.addr == LPI_ADDR_PROX_LO) begin
      rd = r.prox[7:0];
    end else if (bus.addr == LPI_ADDR_CTRL) begin
      rd = r.ctrl;
    end else if (bus.addr == LPI_ADDR_TLO_HI) begin
      rd = r.thr_lo[15:8];
    end else if (bus.addr == LPI_ADDR_TLO_LO) begin
      rd = r.thr_lo[7:0];
    end else if (bus.addr == LPI_ADDR_THI_HI) begin
      rd = r.thr_hi[15:8];
    end else if (bus.addr == LPI_ADDR_THI_LO) begin
      rd = r.thr_hi[7:0];
    end else if (bus.addr == LPI_ADDR_STATUS) begin
      rd = {{(8-LPI_ST_W){1'b0}}, r.flags};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{als: LPI_RES_RST, prox: LPI_RES_RST, thr_lo: LPI_TLO_RST,
             thr_hi: LPI_THI_RST, ctrl: LPI_CTRL_RST, flags: '0,
             run_cnt: '0, param: LPI_PARAM_RST, st_prev: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign bus.rdata = rd;
  assign int_pad_out = 1'b0;
  assign int_pad_oe = |r.flags;
  assign als_param_applied = r.param;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_stat_wr;
    bus.wr && bus.addr == LPI_ADDR_STATUS;
  endsequence

  sequence s_als_wr;
    bus.wr && (bus.addr == LPI_ADDR_ALS_HI || bus.addr == LPI_ADDR_ALS_LO);
  endsequence

  sequence s_prox_wr;
    bus.wr && (bus.addr == LPI_ADDR_PROX_HI || bus.addr == LPI_ADDR_PROX_LO);
  endsequence

  sequence s_sel_hit;
    sel_valid && above && r.ctrl[LPI_THR_EN];
  endsequence

  sequence s_sel_low;
    sel_valid && below && r.ctrl[LPI_THR_EN];
  endsequence

  property p_als_load;
    als_valid |=> r.als == $past(als_in);
  endproperty
  a_als_load: assert property (p_als_load)
    else $error("ambient result not loaded");

  property p_als_ro;
    s_als_wr and !als_valid |=> $stable(r.als);
  endproperty
  a_als_ro: assert property (p_als_ro)
    else $error("ambient result changed by host write");

  property p_prox_load;
    prox_valid |=> r.prox == $past(prox_in);
  endproperty
  a_prox_load: assert property (p_prox_load)
    else $error("proximity result not loaded");

  property p_prox_ro;
    s_prox_wr and !prox_valid |=> $stable(r.prox);
  endproperty
  a_prox_ro: assert property (p_prox_ro)
    else $error("proximity result changed by host write");

  property p_cnt_bound;
    r.run_cnt < persist_tgt |=> r.run_cnt < persist_tgt || $changed(r.ctrl);
  endproperty
  a_cnt_bound: assert property (p_cnt_bound)
    else $error("run counter passed its target");

  property p_one_count;
    s_sel_hit ##0 persist_tgt == 8'h01 |=> r.flags[LPI_ST_HIGH];
  endproperty
  a_one_count: assert property (p_one_count)
    else $error("single-count threshold flag missing");

  property p_one_low;
    s_sel_low ##0 8'(r.run_cnt + 8'h01) >= persist_tgt
      |=> r.flags[LPI_ST_LOW];
  endproperty
  a_one_low: assert property (p_one_low)
    else $error("low threshold flag missing at count end");

  property p_als_rdy;
    als_valid && r.ctrl[LPI_ALS_EN] |=> r.flags[LPI_ST_ALS];
  endproperty
  a_als_rdy: assert property (p_als_rdy)
    else $error("ambient ready flag missing");

  property p_prox_rdy;
    prox_valid && r.ctrl[LPI_PROX_EN] |=> r.flags[LPI_ST_PROX];
  endproperty
  a_prox_rdy: assert property (p_prox_rdy)
    else $error("proximity ready flag missing");

  property p_thr_off;
    !r.ctrl[LPI_THR_EN] |=> !$rose(r.flags[LPI_ST_HIGH])
                           && !$rose(r.flags[LPI_ST_LOW]);
  endproperty
  a_thr_off: assert property (p_thr_off)
    else $error("threshold flag raised while disabled");

  property p_sel_prox;
    !r.ctrl[LPI_THR_SEL] && !prox_valid |=> $stable(r.run_cnt);
  endproperty
  a_sel_prox: assert property (p_sel_prox)
    else $error("counter moved without a proximity sample");

  property p_sel_als;
    r.ctrl[LPI_THR_SEL] && !als_valid |=> $stable(r.run_cnt);
  endproperty
  a_sel_als: assert property (p_sel_als)
    else $error("counter moved without an ambient sample");

  property p_param_hold;
    self_timed_en && r.st_prev |=> $stable(als_param_applied);
  endproperty
  a_param_hold: assert property (p_param_hold)
    else $error("parameter changed during self-timed run");

  property p_thr_wr;
    bus.wr && bus.addr == LPI_ADDR_THI_LO
      |=> r.thr_hi[7:0] == $past(bus.wdata);
  endproperty
  a_thr_wr: assert property (p_thr_wr)
    else $error("high threshold low byte not written");

  property p_tlo_wr;
    bus.wr && bus.addr == LPI_ADDR_TLO_HI
      |=> r.thr_lo[15:8] == $past(bus.wdata);
  endproperty
  a_tlo_wr: assert property (p_tlo_wr)
    else $error("low threshold high byte not written");

  property p_ctrl_wr;
    bus.wr && bus.addr == LPI_ADDR_CTRL |=> r.ctrl == $past(bus.wdata);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr)
    else $error("control register not written");

  property p_sticky;
    !(bus.wr && bus.addr == LPI_ADDR_STATUS)
      |=> (($past(r.flags) & ~r.flags) == '0);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("status flag dropped without a clear");

  property p_w1c;
    s_stat_wr ##0 !als_valid && !prox_valid
      |=> (r.flags & $past(bus.wdata[LPI_ST_W-1:0])) == '0;
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("status flag not cleared by a one");

  property p_int_hold;
    int_pad_oe && !bus.wr |=> int_pad_oe;
  endproperty
  a_int_hold: assert property (p_int_hold)
    else $error("interrupt pin dropped without a host write");

  property p_int_pin;
    int_pad_oe |-> r.flags != '0 ##1 (int_pad_oe || $past(bus.wr));
  endproperty
  a_int_pin: assert property (p_int_pin)
    else $error("interrupt pin released with a flag set");
endmodule : lpi_readout

// >>> common/lpi_pkg.sv
// constants and types for the light/proximity readout block
package lpi_pkg;
  localparam logic [7:0] LPI_ADDR_ALS_HI = 8'h85;
  localparam logic [7:0] LPI_ADDR_ALS_LO = 8'h86;
  localparam logic [7:0] LPI_ADDR_PROX_HI = 8'h87;
  localparam logic [7:0] LPI_ADDR_PROX_LO = 8'h88;
  localparam logic [7:0] LPI_ADDR_CTRL = 8'h89;
  localparam logic [7:0] LPI_ADDR_TLO_HI = 8'h8A;
  localparam logic [7:0] LPI_ADDR_TLO_LO = 8'h8B;
  localparam logic [7:0] LPI_ADDR_THI_HI = 8'h8C;
  localparam logic [7:0] LPI_ADDR_THI_LO = 8'h8D;
  localparam logic [7:0] LPI_ADDR_STATUS = 8'h8E;
  localparam int LPI_CNT_LSB = 5;
  localparam int LPI_CNT_W = 3;
  localparam int LPI_PROX_EN = 3;
  localparam int LPI_ALS_EN = 2;
  localparam int LPI_THR_EN = 1;
  localparam int LPI_THR_SEL = 0;
  localparam int LPI_ST_W = 4;
  localparam int LPI_ST_PROX = 3;
  localparam int LPI_ST_ALS = 2;
  localparam int LPI_ST_LOW = 1;
  localparam int LPI_ST_HIGH = 0;
  localparam logic [7:0] LPI_CTRL_RST = 8'h00;
  localparam logic [15:0] LPI_RES_RST = 16'h0000;
  localparam logic [15:0] LPI_TLO_RST = 16'h0000;
  localparam logic [15:0] LPI_THI_RST = 16'hFFFF;
  localparam logic [7:0] LPI_PARAM_RST = 8'h00;
  localparam logic [7:0] LPI_RD_NONE = 8'h00;
  // bus address of this device, value arbitrary
  localparam logic [6:0] LPI_I2C_ADDR = 7'h2A;
  localparam logic [3:0] LPI_BYTE_BITS = 4'h8;
  localparam logic [3:0] LPI_LAST_BIT = 4'h7;
  localparam logic [1:0] LPI_PH_ADDR = 2'h0;
  localparam logic [1:0] LPI_PH_PTR = 2'h1;
  localparam logic [1:0] LPI_PH_DATA = 2'h2;
  typedef enum logic [2:0] {
    LPI_IDLE, LPI_RX, LPI_RACK, LPI_TX, LPI_TACK
  } lpi_i2c_state_t;
  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    lpi_i2c_state_t state;
    logic [1:0] phase;
    logic [3:0] bits;
    logic [7:0] shift;
    logic rw;
    logic nack;
    logic [7:0] ptr;
    logic [7:0] wdata;
    logic wr;
    logic sda_oe;
  } lpi_i2c_st_t;
  typedef struct packed {
    logic [15:0] als;
    logic [15:0] prox;
    logic [15:0] thr_lo;
    logic [15:0] thr_hi;
    logic [7:0] ctrl;
    logic [LPI_ST_W-1:0] flags;
    logic [7:0] run_cnt;
    logic [7:0] param;
    logic st_prev;
  } lpi_core_st_t;
endpackage : lpi_pkg

// >>> common/lpi_reg_if.sv
// register access path between serial engine and register file
interface lpi_reg_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic [7:0] rdata;
  modport engine (output addr, output wdata, output wr, input rdata);
  modport regs (input addr, input wdata, input wr, output rdata);
endinterface : lpi_reg_if

// >>> hdl/lpi_i2c_slave.sv
// serial two-wire slave turning bus bytes into register accesses
module lpi_i2c_slave
  import lpi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  output logic sda_pin_out,
  output logic sda_pin_oe,
  lpi_reg_if.engine bus
);
  lpi_i2c_st_t r;
  lpi_i2c_st_t n;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  assign scl_rise = r.scl_s2 & ~r.scl_d;
  assign scl_fall = ~r.scl_s2 & r.scl_d;
  assign start_c = r.scl_s2 & r.scl_d & ~r.sda_s2 & r.sda_d;
  assign stop_c = r.scl_s2 & r.scl_d & r.sda_s2 & ~r.sda_d;

  always_comb begin
    n = r;
    n.scl_s1 = scl_pin;
    n.scl_s2 = r.scl_s1;
    n.scl_d = r.scl_s2;
    n.sda_s1 = sda_pin_in;
    n.sda_s2 = r.sda_s1;
    n.sda_d = r.sda_s2;
    n.wr = 1'b0;
    if (start_c) begin
      n.state = LPI_RX;
      n.phase = LPI_PH_ADDR;
      n.bits = '0;
      n.sda_oe = 1'b0;
    end else if (stop_c) begin
      n.state = LPI_IDLE;
      n.sda_oe = 1'b0;
    end else begin
      case (r.state)
        LPI_RX: begin
          if (scl_rise) begin
            n.shift = {r.shift[6:0], r.sda_s2};
            n.bits = 4'(r.bits + 4'h1);
          end else if (scl_fall && r.bits == LPI_BYTE_BITS) begin
            n.bits = '0;
            n.state = LPI_RACK;
            n.sda_oe = 1'b1;
            if (r.phase == LPI_PH_ADDR) begin
              n.rw = r.shift[0];
              if (r.shift[7:1] != LPI_I2C_ADDR) begin
                n.state = LPI_IDLE;
                n.sda_oe = 1'b0;
              end
            end else if (r.phase == LPI_PH_PTR) begin
              n.ptr = r.shift;
            end else begin
              n.wr = 1'b1;
              n.wdata = r.shift;
            end
          end
        end
        LPI_RACK: begin
          if (scl_fall) begin
            n.sda_oe = 1'b0;
            if (r.rw) begin
              n.shift = bus.rdata;
              n.ptr = 8'(r.ptr + 8'h01);
              n.state = LPI_TX;
              n.bits = '0;
              n.sda_oe = ~bus.rdata[7];
            end else begin
              n.state = LPI_RX;
              if (r.phase == LPI_PH_DATA) begin
                n.ptr = 8'(r.ptr + 8'h01);
              end
              n.phase = (r.phase == LPI_PH_ADDR) ? LPI_PH_PTR : LPI_PH_DATA;
            end
          end
        end
        LPI_TX: begin
          if (scl_fall) begin
            if (r.bits == LPI_LAST_BIT) begin
              n.state = LPI_TACK;
              n.sda_oe = 1'b0;
            end else begin
              n.bits = 4'(r.bits + 4'h1);
              n.shift = {r.shift[6:0], 1'b0};
              n.sda_oe = ~r.shift[6];
            end
          end
        end
        LPI_TACK: begin
          if (scl_rise) begin
            n.nack = r.sda_s2;
          end else if (scl_fall) begin
            if (r.nack) begin
              n.state = LPI_IDLE;
            end else begin
              n.shift = bus.rdata;
              n.ptr = 8'(r.ptr + 8'h01);
              n.state = LPI_TX;
              n.bits = '0;
              n.sda_oe = ~bus.rdata[7];
            end
          end
        end
        default: begin
          n.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign bus.addr = r.ptr;
  assign bus.wdata = r.wdata;
  assign bus.wr = r.wr;
  assign sda_pin_out = 1'b0;
  assign sda_pin_oe = r.sda_oe;
endmodule : lpi_i2c_slave

// >>> bench/lpi_host_model.sv
// two-wire bus host model driving the serial register port
module lpi_host_model
  import lpi_pkg::*;
#(
  parameter int Q = 6
) (
  input wire logic sys_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // clock line idles high between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic w;
    repeat (Q) @(negedge sys_clk);
  endtask : w
  task automatic start;
    sda_low = 1'b1;
    w();
    scl = 1'b0;
    w();
  endtask : start
  task automatic stop;
    sda_low = 1'b1;
    w();
    scl = 1'b1;
    w();
    sda_low = 1'b0;
    w();
  endtask : stop
  // one clock pulse; a 1 releases the line, level sampled mid-high
  task automatic bit_io(input logic b, output logic s);
    sda_low = ~b;
    w();
    scl = 1'b1;
    w();
    s = sda;
    w();
    scl = 1'b0;
    w();
  endtask : bit_io
  task automatic xfer(input logic [7:0] d, input logic ab,
    output logic [7:0] r, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(ab, s);
    ack = ~s;
  endtask : xfer
  task automatic wr_reg(input logic [6:0] dev, input logic [7:0] a,
    input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic k;
    start();
    xfer({dev, 1'b0}, 1'b1, r, ok);
    xfer(a, 1'b1, r, k);
    xfer(d, 1'b1, r, k);
    stop();
  endtask : wr_reg
  // pointer write, then upper and lower byte read
  task automatic rd2(input logic [7:0] a, output logic [15:0] v);
    logic [7:0] r;
    logic k;
    start();
    xfer({LPI_I2C_ADDR, 1'b0}, 1'b1, r, k);
    xfer(a, 1'b1, r, k);
    stop();
    start();
    xfer({LPI_I2C_ADDR, 1'b1}, 1'b1, r, k);
    xfer(8'hFF, 1'b0, v[15:8], k);
    xfer(8'hFF, 1'b1, v[7:0], k);
    stop();
  endtask : rd2
endmodule : lpi_host_model

// >>> bench/light_prox_result_irq_ctrl_bench.sv
// self-checking bench for the light and proximity readout block
`define CHK(g, e) \
  begin \
    checked++; \
    if ((g) !== (e)) begin \
      bad_count++; \
      $display("mismatch at %0t got %h exp %h", $time, (g), (e)); \
    end \
  end
module light_prox_result_irq_ctrl_bench
  import lpi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst_n, scl, m_low, sda_oe, int_oe, sda_out, int_out;
  wire logic sda;
  logic [15:0] als_in, prox_in, m_als, m_prox, m_lo, m_hi;
  logic als_valid, prox_valid, st_en;
  logic [7:0] par_in, par_app, m_ctrl;
  logic [3:0] m_flags;
  logic [31:0] seed;
  int m_cnt, bad_count, checked;
  // pulled-up wire level
  assign sda = ~(m_low | sda_oe);
  lpi_readout uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl_pin(scl), .sda_pin_in(sda),
    .sda_pin_out(sda_out), .sda_pin_oe(sda_oe), .int_pad_out(int_out),
    .int_pad_oe(int_oe), .als_in(als_in), .als_valid(als_valid),
    .prox_in(prox_in), .prox_valid(prox_valid), .self_timed_en(st_en),
    .als_param_in(par_in), .als_param_applied(par_app)
  );
  lpi_host_model host (
    .sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(m_low)
  );
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [7:0] eb(input logic [7:0] a);
    case (a)
      LPI_ADDR_ALS_HI: return m_als[15:8];
      LPI_ADDR_ALS_LO: return m_als[7:0];
      LPI_ADDR_PROX_HI: return m_prox[15:8];
      LPI_ADDR_PROX_LO: return m_prox[7:0];
      LPI_ADDR_CTRL: return m_ctrl;
      LPI_ADDR_TLO_HI: return m_lo[15:8];
      LPI_ADDR_TLO_LO: return m_lo[7:0];
      LPI_ADDR_THI_HI: return m_hi[15:8];
      LPI_ADDR_THI_LO: return m_hi[7:0];
      LPI_ADDR_STATUS: return {4'h0, m_flags};
      default: return LPI_RD_NONE;
    endcase
  endfunction : eb
  task automatic wrap_up;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic rd(input logic [7:0] a);
    logic [15:0] v;
    host.rd2(a, v);
    `CHK(v, {eb(a), eb(a + 8'h01)})
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.wr_reg(LPI_I2C_ADDR, a, d, ok);
    `CHK(ok, 1'b1)
    case (a)
      LPI_ADDR_CTRL: m_ctrl = d;
      LPI_ADDR_TLO_HI: m_lo[15:8] = d;
      LPI_ADDR_TLO_LO: m_lo[7:0] = d;
      LPI_ADDR_THI_HI: m_hi[15:8] = d;
      LPI_ADDR_THI_LO: m_hi[7:0] = d;
      LPI_ADDR_STATUS: m_flags &= ~d[3:0];
      default: ;
    endcase
  endtask : wr
  // one measurement strobe and the model's view of it
  task automatic meas(input logic [15:0] a, input logic [15:0] p,
    input logic sa, input logic sp);
    logic [15:0] v;
    logic s;
    @(negedge sys_clk);
    s = m_ctrl[LPI_THR_SEL];
    v = s ? a : p;
    als_in = a;
    prox_in = p;
    als_valid = sa;
    prox_valid = sp;
    @(negedge sys_clk);
    als_valid = 1'b0;
    prox_valid = 1'b0;
    if (sa) begin
      m_als = a;
      m_flags[LPI_ST_ALS] |= m_ctrl[LPI_ALS_EN];
    end
    if (sp) begin
      m_prox = p;
      m_flags[LPI_ST_PROX] |= m_ctrl[LPI_PROX_EN];
    end
    if (s ? sa : sp) begin
      if (v > m_hi || v < m_lo) begin
        m_cnt++;
        if (m_cnt == (1 << m_ctrl[7:5])) begin
          m_cnt = 0;
          if (m_ctrl[LPI_THR_EN]) begin
            m_flags[(v > m_hi) ? LPI_ST_HIGH : LPI_ST_LOW] = 1'b1;
          end
        end
      end else begin
        m_cnt = 0;
      end
    end
    `CHK(int_oe, |m_flags)
    `CHK({sda_out, int_out}, 2'b00)
  endtask : meas
  initial begin
    for (int i = 0; i < 95000; i++) begin
      @(negedge sys_clk);
    end
    bad_count++;
    wrap_up();
  end
  initial begin
    logic ok;
    logic [15:0] o;
    rst_n = 1'b0;
    als_in = 16'h0000;
    prox_in = 16'h0000;
    als_valid = 1'b0;
    prox_valid = 1'b0;
    st_en = 1'b0;
    par_in = 8'h00;
    bad_count = 0;
    checked = 0;
    m_cnt = 0;
    seed = 32'h0001_7EB4;
    m_als = LPI_RES_RST;
    m_prox = LPI_RES_RST;
    m_lo = LPI_TLO_RST;
    m_hi = LPI_THI_RST;
    m_ctrl = LPI_CTRL_RST;
    m_flags = 4'h0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    // foreign device address is ignored
    host.wr_reg(LPI_I2C_ADDR ^ 7'h01, LPI_ADDR_CTRL, 8'hFF, ok);
    `CHK(ok, 1'b0)
    for (int a = 8'h85; a < 8'h91; a += 2) begin
      rd(8'(a));
    end
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      meas(seed[15:0], seed[31:16], 1'b1, 1'b1);
      rd(LPI_ADDR_ALS_HI);
      rd(LPI_ADDR_PROX_HI);
    end
    wr(LPI_ADDR_ALS_HI, 8'hA5);
    wr(LPI_ADDR_PROX_LO, 8'h5A);
    rd(LPI_ADDR_ALS_HI);
    rd(LPI_ADDR_PROX_HI);
    // ready flags, each with only its own enable
    for (int k = 0; k < 2; k++) begin
      wr(LPI_ADDR_CTRL, k ? 8'h04 : 8'h08);
      seed = lfsr(seed);
      meas(seed[15:0], seed[31:16], ~k[0], k[0]);
      meas(seed[31:16], seed[15:0], k[0], ~k[0]);
      rd(LPI_ADDR_STATUS);
      wr(LPI_ADDR_STATUS, 8'h00);
      `CHK(int_oe, |m_flags)
      wr(LPI_ADDR_STATUS, 8'h0F);
      `CHK(int_oe, |m_flags)
    end
    wr(LPI_ADDR_TLO_HI, 8'h01);
    wr(LPI_ADDR_TLO_LO, 8'h00);
    wr(LPI_ADDR_THI_HI, 8'h02);
    wr(LPI_ADDR_THI_LO, 8'h00);
    rd(LPI_ADDR_TLO_HI);
    rd(LPI_ADDR_THI_HI);
    // every count code, both sources, equal-to-limit stays in range
    for (int s = 0; s < 2; s++) begin
      for (int n = 0; n < 8; n++) begin
        wr(LPI_ADDR_CTRL, {n[2:0], 4'h1, s[0]});
        meas(16'h0200, 16'h0100, 1'b1, 1'b1);
        o = n[0] ? 16'h00FF : 16'h0201;
        for (int i = 0; i < (1 << n); i++) begin
          meas(s ? o : 16'h0150, s ? 16'h0150 : o, 1'b1, 1'b1);
        end
        if (n < 2) begin
          rd(LPI_ADDR_STATUS);
        end
        wr(LPI_ADDR_STATUS, 8'h03);
      end
    end
    // parameter frozen while self-timed mode runs
    par_in = 8'h11;
    repeat (2) @(negedge sys_clk);
    `CHK(par_app, 8'h11)
    st_en = 1'b1;
    repeat (2) @(negedge sys_clk);
    par_in = 8'h22;
    repeat (2) @(negedge sys_clk);
    `CHK(par_app, 8'h11)
    st_en = 1'b0;
    @(negedge sys_clk);
    st_en = 1'b1;
    repeat (2) @(negedge sys_clk);
    `CHK(par_app, 8'h22)
    wrap_up();
  end
endmodule : light_prox_result_irq_ctrl_bench
